/* File: core/flash_ctrl_map.svh */
// Operation
// - Data pair 14 bits, address pair 15 bits
// - Address high byte plus low byte, 32K words
// - Internal timer ends erase and program
// - Code protect blocks programmer, not self-write
// - Programmer bulk erase or power-up reset lifts code protect
// - Write-protect field refuses self erase, write
// - Strobes set only, hardware clears on completion
// - Erase/write need write_allow, zero at power-up
// - Reset during write sets write_abort_flag
// - Unlock key port reads as zero
// - Rows of 16 fourteen-bit words
// - Latches filled only through data pair
// - Read uses second slot, discards it
// - Data pair holds last read word
// - Keys 55h then AAh then write strobe
// - Interrupted unlock performs no operation
// - Write strobe forces two no-op slots
// - Erase or program stalls about 2 ms
// - Latch load: two no-ops, no stall
// - Latch-only loads latch, else programs or erases row
// - Low four bits latch, upper eleven row
// - Latches return blank after write or erase
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
`define OFS_DATA_LOW 8'h00
`define OFS_DATA_HIGH 8'h04
`define OFS_ADDR_LOW 8'h08
`define OFS_ADDR_HIGH 8'h0C
`define OFS_CTRL 8'h10
`define OFS_KEY 8'h14
`define OFS_CONFIG 8'h18
`define BIT_RD 0
`define BIT_WR 1
`define BIT_ALLOW 2
`define BIT_ABORT 3
`define BIT_ERASE 4
`define BIT_LATCH_ONLY 5
`define BIT_CFG_SEL 6
`define BIT_CP_N 2
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
`define BLANK_WORD 14'h3FFF
`define WP_NONE 2'h3
`define WP_QUARTER 2'h2
`define WP_HALF 2'h1
`define PROG_TIME_NS 2000000
`define CLK_MHZ 125
`endif

/* File: core/flash_ctrl_pkg.sv */
package flash_ctrl_pkg;
  typedef enum logic [1:0] {
    unlk_idle,
    unlk_got_first,
    unlk_got_second
  } unlock_state_t;
  typedef enum logic [2:0] {
    st_idle,
    st_slot1,
    st_slot2,
    st_stream,
    st_timer
  } op_state_t;
  // Request toward the flash array
  typedef struct packed {
    logic rd;
    logic erase;
    logic word_we;
    logic bulk_erase;
    logic cfg_space;
    logic [14:0] addr;
    logic [13:0] wdata;
  } flash_req_t;
endpackage

/* File: core/flash_self_program_ctrl.sv */
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_self_program_ctrl #(
  parameter int ADDR_W = 15,
  parameter int WORD_W = 14,
  parameter int ROW_WORDS = 16,
  parameter int PROG_CYCLES = `PROG_TIME_NS * `CLK_MHZ / 1000,
  parameter logic [14:0] WP_QUARTER_END = 15'h0200,
  parameter logic [14:0] WP_HALF_END = 15'h0400
) (
  // Clock and power-up reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor core
  input wire logic dev_reset_n,
  output logic insn_discard,
  output logic cpu_stall,
  // Flash array
  input wire logic [13:0] fl_rdata,
  output flash_ctrl_pkg::flash_req_t fl_req,
  // External programmer pins
  input wire logic ext_bulk_erase,
  output logic ext_access_ok
);
  import flash_ctrl_pkg::*;

  localparam int IDX_W = $clog2(ROW_WORDS);

  if (ADDR_W != 15 || WORD_W != 14 || ROW_WORDS != 16 || PROG_CYCLES < 1)
  begin : g_check
    $error("flash_self_program_ctrl: unsupported parameters");
  end

  logic [7:0] data_low_r;
  logic [5:0] data_high_r;
  logic [7:0] addr_low_r;
  logic [6:0] addr_high_r;
  logic rd_r, wr_r, write_allow_r, abort_r, erase_r, latch_only_r;
  logic cfg_sel_r, code_protect_n_r;
  logic [1:0] wp_field_r;
  logic [13:0] latch_mem [ROW_WORDS];
  unlock_state_t unlk_r;
  op_state_t st_r, st_nxt;
  logic op_wr_r;
  logic [IDX_W-1:0] idx_r;
  logic [31:0] tmr_r;
  logic bulk_s1_r, bulk_s2_r, bulk_s3_r;
  logic acc, wr_acc, rd_acc, ctrl_wr, key_wr, start_rd, start_wr;
  logic prot_hit, tmr_done, bulk_edge;
  logic [14:0] word_addr;

  assign word_addr = {addr_high_r, addr_low_r};
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign ctrl_wr = wr_acc && paddr == `OFS_CTRL;
  assign key_wr = wr_acc && paddr == `OFS_KEY;
  assign tmr_done = tmr_r == 32'(PROG_CYCLES - 1);
  assign bulk_edge = bulk_s2_r && !bulk_s3_r;

  // Self-write refused inside the protected region
  always_comb begin
    case (wp_field_r)
      `WP_NONE: prot_hit = 1'b0;
      `WP_QUARTER: prot_hit = word_addr < WP_QUARTER_END;
      `WP_HALF: prot_hit = word_addr < WP_HALF_END;
      default: prot_hit = 1'b1;
    endcase
  end

  assign start_rd = ctrl_wr && pwdata[`BIT_RD] && st_r == st_idle;
  assign start_wr = ctrl_wr && pwdata[`BIT_WR] && st_r == st_idle &&
    unlk_r == unlk_got_second && write_allow_r && !prot_hit;

  // APB: one wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && paddr > `OFS_CONFIG;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `OFS_DATA_LOW: prdata <= {24'h000000, data_low_r};
          `OFS_DATA_HIGH: prdata <= {26'h0000000, data_high_r};
          `OFS_ADDR_LOW: prdata <= {24'h000000, addr_low_r};
          `OFS_ADDR_HIGH: prdata <= {25'h0000000, addr_high_r};
          `OFS_CTRL: prdata <= {25'h0000000, cfg_sel_r, latch_only_r,
            erase_r, abort_r, write_allow_r, wr_r, rd_r};
          `OFS_CONFIG: prdata <= {29'h00000000, code_protect_n_r,
            wp_field_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Unlock detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlk_r <= unlk_idle;
    end else if (acc) begin
      case (unlk_r)
        unlk_idle:
          if (key_wr && pwdata[7:0] == `KEY_FIRST) unlk_r <= unlk_got_first;
        unlk_got_first:
          if (key_wr && pwdata[7:0] == `KEY_SECOND) begin
            unlk_r <= unlk_got_second;
          end else begin
            unlk_r <= unlk_idle;
          end
        default: unlk_r <= unlk_idle;
      endcase
    end
  end

  // Address pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low_r <= 8'h00;
      addr_high_r <= 7'h00;
    end else if (wr_acc) begin
      if (paddr == `OFS_ADDR_LOW) addr_low_r <= pwdata[7:0];
      if (paddr == `OFS_ADDR_HIGH) addr_high_r <= pwdata[6:0];
    end
  end

  // Data pair: software write or completed read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_low_r <= 8'h00;
      data_high_r <= 6'h00;
    end else if (st_r == st_slot2 && !op_wr_r) begin
      {data_high_r, data_low_r} <= fl_rdata;
    end else if (wr_acc) begin
      if (paddr == `OFS_DATA_LOW) data_low_r <= pwdata[7:0];
      if (paddr == `OFS_DATA_HIGH) data_high_r <= pwdata[5:0];
    end
  end

  // Control bits; strobes cannot be cleared by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      write_allow_r <= 1'b0;
      erase_r <= 1'b0;
      latch_only_r <= 1'b0;
      cfg_sel_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        write_allow_r <= pwdata[`BIT_ALLOW];
        erase_r <= pwdata[`BIT_ERASE];
        latch_only_r <= pwdata[`BIT_LATCH_ONLY];
        cfg_sel_r <= pwdata[`BIT_CFG_SEL];
      end
      if (!dev_reset_n) begin
        rd_r <= 1'b0;
        wr_r <= 1'b0;
      end else if (start_wr) begin
        wr_r <= 1'b1;
      end else if (start_rd) begin
        rd_r <= 1'b1;
      end else if (st_nxt == st_idle) begin
        rd_r <= 1'b0;
        wr_r <= 1'b0;
      end
    end
  end

  // Abort flag: device reset in mid-write sets it, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_r <= 1'b0;
    end else if (!dev_reset_n && op_wr_r && st_r != st_idle) begin
      abort_r <= 1'b1;
    end else if (ctrl_wr && !pwdata[`BIT_ABORT]) begin
      abort_r <= 1'b0;
    end
  end

  // Protection configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_protect_n_r <= 1'b1;
      wp_field_r <= `WP_NONE;
      ext_access_ok <= 1'b0;
    end else begin
      if (bulk_edge) begin
        code_protect_n_r <= 1'b1;
        wp_field_r <= `WP_NONE;
      end else if (wr_acc && paddr == `OFS_CONFIG) begin
        wp_field_r <= pwdata[1:0];
        if (!pwdata[`BIT_CP_N]) code_protect_n_r <= 1'b0;
      end
      ext_access_ok <= code_protect_n_r;
    end
  end

  // Bulk-erase pin synchroniser and edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bulk_s1_r <= 1'b0;
      bulk_s2_r <= 1'b0;
      bulk_s3_r <= 1'b0;
    end else begin
      bulk_s1_r <= ext_bulk_erase;
      bulk_s2_r <= bulk_s1_r;
      bulk_s3_r <= bulk_s2_r;
    end
  end

  // Operation sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      st_idle:
        if (start_wr || start_rd) st_nxt = st_slot1;
      st_slot1: st_nxt = st_slot2;
      st_slot2:
        if (!op_wr_r || latch_only_r) begin
          st_nxt = st_idle;
        end else if (erase_r) begin
          st_nxt = st_timer;
        end else begin
          st_nxt = st_stream;
        end
      st_stream:
        if (idx_r == IDX_W'(ROW_WORDS - 1)) st_nxt = st_timer;
      st_timer:
        if (tmr_done) st_nxt = st_idle;
      default: st_nxt = st_idle;
    endcase
    if (!dev_reset_n) st_nxt = st_idle;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= st_idle;
      op_wr_r <= 1'b0;
      idx_r <= '0;
      tmr_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      if (st_r == st_idle) op_wr_r <= start_wr;
      idx_r <= (st_r == st_stream) ? idx_r + 1'b1 : '0;
      tmr_r <= (st_r == st_timer) ? tmr_r + 32'h1 : 32'h0;
    end
  end

  // Slots seen by the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn_discard <= 1'b0;
      cpu_stall <= 1'b0;
    end else begin
      insn_discard <= st_nxt == st_slot2 ||
        (st_nxt == st_slot1 && (op_wr_r || start_wr));
      cpu_stall <= st_nxt == st_stream || st_nxt == st_timer;
    end
  end

  // Write latches, one per word of the row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ROW_WORDS; i++) latch_mem[i] <= `BLANK_WORD;
    end else if ((st_r == st_timer && tmr_done) || bulk_edge) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        latch_mem[i] <= `BLANK_WORD;
      end
    end else if (st_r == st_slot2 && op_wr_r &&
        (latch_only_r || !erase_r)) begin
      // Program run loads its own word too, before the row is streamed
      latch_mem[addr_low_r[3:0]] <= {data_high_r, data_low_r};
    end
  end

  // Requests toward the array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_req <= '0;
    end else begin
      fl_req.rd <= st_r == st_slot1 && !op_wr_r;
      fl_req.erase <= st_r == st_slot2 && op_wr_r && !latch_only_r &&
        erase_r;
      fl_req.word_we <= st_r == st_stream;
      fl_req.bulk_erase <= bulk_edge;
      fl_req.cfg_space <= cfg_sel_r;
      fl_req.addr <= (st_r == st_stream) ?
        {word_addr[14:4], idx_r} : word_addr;
      fl_req.wdata <= latch_mem[idx_r];
    end
  end

  // Checks
  sequence s_rd_start;
    start_rd && !start_wr;
  endsequence
  sequence s_wr_start;
    start_wr;
  endsequence

  property p_rd_timing;
    @(posedge pclk) disable iff (!presetn || !dev_reset_n)
      s_rd_start |-> ##1 fl_req.rd == 1'b0 ##1 insn_discard && fl_req.rd
      ##1 !rd_r;
  endproperty
  a_rd_timing: assert property (p_rd_timing)
    else $error("read slot timing wrong");

  property p_wr_nops;
    @(posedge pclk) disable iff (!presetn || !dev_reset_n)
      s_wr_start |=> insn_discard [*2];
  endproperty
  a_wr_nops: assert property (p_wr_nops)
    else $error("write strobe did not force two no-ops");

  property p_latch_no_stall;
    @(posedge pclk) disable iff (!presetn || !dev_reset_n)
      s_wr_start ##1 latch_only_r |-> ##2 !cpu_stall && !wr_r;
  endproperty
  a_latch_no_stall: assert property (p_latch_no_stall)
    else $error("latch load stalled or strobe stuck");

  property p_erase_stall;
    @(posedge pclk) disable iff (!presetn || !dev_reset_n)
      s_wr_start ##1 (erase_r && !latch_only_r) |-> ##2 cpu_stall;
  endproperty
  a_erase_stall: assert property (p_erase_stall)
    else $error("erase did not stall the core");

  property p_locked;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_wr && st_r == st_idle && unlk_r != unlk_got_second)
      |=> !wr_r;
  endproperty
  a_locked: assert property (p_locked)
    else $error("write started without unlock");

  property p_protect;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_wr && st_r == st_idle && prot_hit) |=> !wr_r;
  endproperty
  a_protect: assert property (p_protect)
    else $error("write started in protected region");

  property p_key_zero;
    @(posedge pclk) disable iff (!presetn)
      (rd_acc && paddr == `OFS_KEY) |-> prdata == 32'h0000_0000;
  endproperty
  a_key_zero: assert property (p_key_zero)
    else $error("key port read not zero");

  property p_blank;
    @(posedge pclk) disable iff (!presetn)
      (st_r == st_timer && tmr_done) |=> latch_mem[0] == `BLANK_WORD &&
      st_r == st_idle && !cpu_stall;
  endproperty
  a_blank: assert property (p_blank)
    else $error("latches not blank after operation");

  property p_abort;
    @(posedge pclk) disable iff (!presetn)
      (!dev_reset_n && op_wr_r && st_r != st_idle) |=> abort_r && !wr_r;
  endproperty
  a_abort: assert property (p_abort)
    else $error("interrupted write not flagged");

  property p_cp_lift;
    @(posedge pclk) disable iff (!presetn)
      $rose(code_protect_n_r) |-> $past(bulk_edge);
  endproperty
  a_cp_lift: assert property (p_cp_lift)
    else $error("code protect lifted without bulk erase");

endmodule // flash_self_program_ctrl

/* File: verif/flash_array_model.sv */
`timescale 1ns/1ps
module flash_array_model (
  // Clock and request from the controller
  input wire logic pclk,
  input wire flash_ctrl_pkg::flash_req_t fl_req,
  // Word read back
  output logic [13:0] fl_rdata
);
  import flash_ctrl_pkg::*;
  logic [13:0] mem [0:32767];
  // Known pattern so that untouched words can be told apart
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 14'(i) ^ 14'h2A5A;
    end
  end
  // Not selected: show the inverse, never a stale word
  assign fl_rdata = fl_req.rd ? mem[fl_req.addr] : ~mem[fl_req.addr];
  always @(posedge pclk) begin
    if (fl_req.bulk_erase) begin
      for (int i = 0; i < 32768; i++) begin
        mem[i] <= 14'h3FFF;
      end
    end else if (fl_req.erase) begin
      for (int k = 0; k < 16; k++) begin
        mem[{fl_req.addr[14:4], 4'(k)}] <= 14'h3FFF;
      end
    end else if (fl_req.word_we) begin
      // Programming only clears bits
      mem[fl_req.addr] <= mem[fl_req.addr] & fl_req.wdata;
    end
  end
endmodule // flash_array_model

/* File: verif/flash_self_program_ctrl_test.sv */
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_self_program_ctrl_test;
  import flash_ctrl_pkg::*;
  localparam int PROG_N = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic dev_reset_n = 1'b1;
  logic ext_bulk_erase = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic insn_discard;
  logic cpu_stall;
  logic ext_access_ok;
  logic [13:0] fl_rdata;
  flash_req_t fl_req;
  logic [31:0] rd_v;
  logic slv_v;
  int num_errors = 0;
  int check_count = 0;
  int stall_cnt = 0;
  int disc_cnt = 0;
  int we_cnt = 0;
  int data_cnt = 0;
  int s0;
  int d0;
  int w0;
  int p0;

  flash_self_program_ctrl #(.PROG_CYCLES(PROG_N)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_reset_n(dev_reset_n),
    .insn_discard(insn_discard), .cpu_stall(cpu_stall),
    .fl_rdata(fl_rdata), .fl_req(fl_req), .ext_bulk_erase(ext_bulk_erase),
    .ext_access_ok(ext_access_ok));
  flash_array_model array (.pclk(pclk), .fl_req(fl_req),
    .fl_rdata(fl_rdata));

  always #4 pclk = ~pclk;
  // Cycle counters for stall, forced no-ops and programmed words
  always @(posedge pclk) begin
    if (cpu_stall === 1'b1) stall_cnt <= stall_cnt + 1;
    if (insn_discard === 1'b1) disc_cnt <= disc_cnt + 1;
    if (fl_req.word_we === 1'b1) we_cnt <= we_cnt + 1;
    if (fl_req.word_we === 1'b1 && fl_req.wdata !== 14'h3FFF) begin
      data_cnt <= data_cnt + 1;
    end
  end

  function automatic logic [13:0] pat(input logic [14:0] a);
    return a[13:0] ^ 14'h2A5A;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    slv_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic set_addr(input logic [14:0] a);
    apb(1'b1, `OFS_ADDR_LOW, {24'h0, a[7:0]});
    apb(1'b1, `OFS_ADDR_HIGH, {25'h0, a[14:8]});
  endtask

  task automatic set_data(input logic [13:0] w);
    apb(1'b1, `OFS_DATA_LOW, {24'h0, w[7:0]});
    apb(1'b1, `OFS_DATA_HIGH, {26'h0, w[13:8]});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_CTRL, 32'h0);
      n++;
    end while (rd_v[1:0] !== 2'b00 && n < 50);
    if (n >= 50) num_errors++;
  endtask

  task automatic unlock(input logic [31:0] ctl);
    apb(1'b1, `OFS_CTRL, ctl);
    apb(1'b1, `OFS_KEY, 32'h55);
    apb(1'b1, `OFS_KEY, 32'hAA);
    apb(1'b1, `OFS_CTRL, ctl | 32'h2);
  endtask

  task automatic read_word(input logic [14:0] a, output logic [13:0] w);
    set_addr(a);
    apb(1'b1, `OFS_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    wait_idle();
    apb(1'b0, `OFS_DATA_LOW, 32'h0);
    w[7:0] = rd_v[7:0];
    apb(1'b0, `OFS_DATA_HIGH, 32'h0);
    w[13:8] = rd_v[5:0];
  endtask

  task automatic chk_word(input logic [14:0] a, input logic [13:0] exp);
    logic [13:0] w;
    read_word(a, w);
    check({18'h0, w}, {18'h0, exp});
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OFS_CTRL, 32'h0);
    check(rd_v, 32'h0);
    apb(1'b0, `OFS_CONFIG, 32'h0);
    check(rd_v, 32'h7);
    check({31'h0, ext_access_ok}, 32'h1);
    apb(1'b1, `OFS_KEY, 32'h55);
    apb(1'b0, `OFS_KEY, 32'h0);
    check(rd_v, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, slv_v}, 32'h1);
    apb(1'b1, `OFS_ADDR_HIGH, 32'hFF);
    apb(1'b0, `OFS_ADDR_HIGH, 32'h0);
    check(rd_v, 32'h7F);
    apb(1'b1, `OFS_DATA_HIGH, 32'hFF);
    apb(1'b0, `OFS_DATA_HIGH, 32'h0);
    check(rd_v, 32'h3F);
    // Word read with one discarded slot
    d0 = disc_cnt;
    chk_word(15'h5234, pat(15'h5234));
    check(32'(disc_cnt - d0), 32'h1);
    set_addr(15'h0000);
    apb(1'b0, `OFS_DATA_LOW, 32'h0);
    check(rd_v, {18'h0, pat(15'h5234) & 14'h00FF});
    // Row erase, software cannot clear the strobe
    set_addr(15'h0817);
    s0 = stall_cnt;
    unlock(32'h14);
    apb(1'b1, `OFS_CTRL, 32'h04);
    apb(1'b0, `OFS_CTRL, 32'h0);
    check({31'h0, rd_v[1]}, 32'h1);
    wait_idle();
    check({31'h0, stall_cnt - s0 >= PROG_N}, 32'h1);
    for (int k = 0; k < 16; k++) begin
      chk_word(15'h0810 + 15'(k), 14'h3FFF);
    end
    chk_word(15'h0820, pat(15'h0820));
    // Latch load then row program
    set_addr(15'h0812);
    set_data(14'h1234);
    s0 = stall_cnt;
    d0 = disc_cnt;
    unlock(32'h24);
    wait_idle();
    check(32'(stall_cnt - s0), 32'h0);
    check(32'(disc_cnt - d0), 32'h2);
    set_addr(15'h0813);
    set_data(14'h2BCD);
    s0 = stall_cnt;
    w0 = we_cnt;
    p0 = data_cnt;
    unlock(32'h04);
    wait_idle();
    check({31'h0, stall_cnt - s0 >= PROG_N}, 32'h1);
    check(32'(we_cnt - w0), 32'h10);
    check(32'(data_cnt - p0), 32'h2);
    chk_word(15'h0812, 14'h1234);
    chk_word(15'h0813, 14'h2BCD);
    chk_word(15'h0814, 14'h3FFF);
    // Second program: latches must be blank again
    set_addr(15'h0815);
    set_data(14'h0000);
    p0 = data_cnt;
    unlock(32'h04);
    wait_idle();
    check(32'(data_cnt - p0), 32'h1);
    // Broken unlock: interleaved access, then wrong order
    set_addr(15'h0830);
    for (int t = 0; t < 2; t++) begin
      apb(1'b1, `OFS_CTRL, 32'h14);
      apb(1'b1, `OFS_KEY, (t == 0) ? 32'h55 : 32'hAA);
      if (t == 0) apb(1'b0, `OFS_CTRL, 32'h0);
      apb(1'b1, `OFS_KEY, (t == 0) ? 32'hAA : 32'h55);
      apb(1'b1, `OFS_CTRL, 32'h16);
      wait_idle();
      chk_word(15'h0830, pat(15'h0830));
    end
    set_addr(15'h0830);
    unlock(32'h10);
    wait_idle();
    chk_word(15'h0830, pat(15'h0830));
    // Device reset in mid-erase
    set_addr(15'h0840);
    unlock(32'h14);
    repeat (5) @(posedge pclk);
    dev_reset_n <= 1'b0;
    @(posedge pclk);
    dev_reset_n <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OFS_CTRL, 32'h0);
    check({28'h0, rd_v[3:0]}, 32'hC);
    // Lower quarter protected
    apb(1'b1, `OFS_CONFIG, 32'h6);
    set_addr(15'h0100);
    unlock(32'h14);
    wait_idle();
    chk_word(15'h0100, pat(15'h0100));
    // Code protect keeps self-erase working
    apb(1'b1, `OFS_CONFIG, 32'h3);
    // Pin output follows the protect bit one cycle later
    @(posedge pclk);
    check({31'h0, ext_access_ok}, 32'h0);
    set_addr(15'h0300);
    unlock(32'h14);
    wait_idle();
    chk_word(15'h0300, 14'h3FFF);
    apb(1'b1, `OFS_CONFIG, 32'h7);
    apb(1'b0, `OFS_CONFIG, 32'h0);
    check(rd_v, 32'h3);
    ext_bulk_erase <= 1'b1;
    repeat (5) @(posedge pclk);
    ext_bulk_erase <= 1'b0;
    repeat (5) @(posedge pclk);
    check({31'h0, ext_access_ok}, 32'h1);
    chk_word(15'h0812, 14'h3FFF);
    give_verdict();
  end
endmodule // flash_self_program_ctrl_test
